/* src/apts_defs.svh */
// Timing, framing and serial command constants for the transfer supervisor.
`ifndef APTS_DEFS_SVH
`define APTS_DEFS_SVH
`define APTS_CLK_NS 8
`define APTS_TICK_NS 1000000
`define APTS_MODE_LIMIT_MS 13'h1388
`define APTS_REQ_LIMIT_MS 13'h03e8
`define APTS_READY_LIMIT_MS 13'h03e8
`define APTS_TIMER_MAX 13'h1fff
`define APTS_DATA_PAIRS 5'h10
`define APTS_TOTAL_PAIRS 5'h13
`define APTS_SUM_TRIES 3'h4
`define APTS_SUM_LSB 32
`define APTS_READ_CMD 8'h02
`define APTS_READ_DATA_NO 8'h91
`endif

/* src/apts_pkg.sv */
// Types shared by the transfer supervisor.
`default_nettype none
package apts_pkg;
  typedef enum logic [2:0] {
    IDLE, START, ACK, REQ, CHECK, GAP, DONE, HALT
  } apts_state_type;
endpackage
`default_nettype wire

/* src/apts_supervisor.sv */
// Position FIFO and absolute position transfer supervisor for one axis.
`timescale 1ns/1ps
`default_nettype none
`include "apts_defs.svh"

module apts_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic core_clk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic inValid, // Write request.
  output logic inReady, // Space available.
  input wire logic [WIDTH-1:0] inData, // Write data.
  output logic outValid, // Data available.
  input wire logic outReady, // Reader takes a word.
  output logic [WIDTH-1:0] outData // Head word.
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_reg;
  logic [AW:0] rdPtr_reg;
  logic doWrite;
  logic doRead;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("apts_fifo: DEPTH must be a power of two of at least 2");
  end

  assign outValid = wrPtr_reg != rdPtr_reg;
  assign inReady = wrPtr_reg != {~rdPtr_reg[AW], rdPtr_reg[AW-1:0]};
  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;
  assign outData = mem[rdPtr_reg[AW-1:0]];

  always_ff @(posedge core_clk) begin
    if (doWrite) begin
      mem[wrPtr_reg[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end else begin
      if (doWrite) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (doRead) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
    end
  end
endmodule

module apts_supervisor #(
  parameter int TICK_CYCLES = `APTS_TICK_NS / `APTS_CLK_NS,
  parameter bit MULTI_AXIS = 1'b1,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic core_clk, // System clock, 125 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic servoOnSwitch, // Operator servo-on switch pin.
  input wire logic alarmResetSwitch, // Alarm reset switch pin.
  input wire logic faultOutput, // Amplifier fault pin, high on fault.
  input wire logic emergencyStopInput, // High while emergency stop is active.
  input wire logic transferReadyOutput, // Amplifier transfer-ready pin.
  input wire logic positionBitZero, // Amplifier data bit 0 pin.
  input wire logic positionBitOne, // Amplifier data bit 1 pin.
  output logic servoOnCmd, // Servo-on drive to the amplifier.
  output logic transferMode, // Transfer mode drive to the amplifier.
  output logic requestOut, // Data request drive to the amplifier.
  output logic torqueLimiting, // Torque limiting status.
  output logic commError, // Communication error flag.
  output logic sumError, // Checksum error flag.
  output logic servoAlarm, // Servo alarm flag.
  output logic posValid, // Position word available.
  input wire logic posReady, // Position word taken.
  output logic [31:0] posData, // Absolute position, pulse units.
  input wire logic serialReq, // Pulse: start a serial position read.
  input wire logic [7:0] stationNo, // Station to address.
  output logic serialCmdValid, // Serial command pending.
  input wire logic serialCmdReady, // Serial link accepted the command.
  output logic [7:0] serialStation, // Station of the pending command.
  output logic [7:0] serialCmdCode, // Command code of the pending command.
  output logic [7:0] serialDataNo // Data number of the pending command.
);
  localparam int PW = 20;

  if (TICK_CYCLES < 1 || TICK_CYCLES >= (1 << PW)) begin : g_chk
    $error("apts_supervisor: TICK_CYCLES out of range");
  end

  function automatic logic [12:0] bump(input logic [12:0] v);
    bump = (v == `APTS_TIMER_MAX) ? v : 13'(v + 13'h1);
  endfunction

  function automatic logic [5:0] pairSum(input logic [31:0] d);
    logic [5:0] s;
    s = 6'h0;
    for (int i = 0; i < 16; i++) begin
      s = 6'(s + {4'h0, d[2*i +: 2]});
    end
    pairSum = s;
  endfunction

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  // Every pin stage, timer and counter lives in this instance, so axes never share state.
  logic [6:0] pinMeta_reg;
  logic [6:0] pinSync_reg;
  logic sonLast_reg;
  logic arsLast_reg;
  logic sonS, arsS, faultS, emgS, readyS, bit0S, bit1S;
  logic sonRise, arsRise;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinMeta_reg <= '0;
      pinSync_reg <= '0;
      sonLast_reg <= 1'b0;
      arsLast_reg <= 1'b0;
    end else begin
      pinMeta_reg <= {servoOnSwitch, alarmResetSwitch, faultOutput,
                      emergencyStopInput, transferReadyOutput,
                      positionBitZero, positionBitOne};
      pinSync_reg <= pinMeta_reg;
      sonLast_reg <= pinSync_reg[6];
      arsLast_reg <= pinSync_reg[5];
    end
  end

  assign {sonS, arsS, faultS, emgS, readyS, bit0S, bit1S} = pinSync_reg;
  assign sonRise = sonS && !sonLast_reg;
  assign arsRise = arsS && !arsLast_reg;

  // ------------------------------------------------------------
  // Millisecond tick and phase timers
  // ------------------------------------------------------------
  logic [PW-1:0] prescale_reg;
  logic msTick;
  logic [12:0] modeMs_reg;
  logic [12:0] reqMs_reg;
  logic [12:0] lowMs_reg;
  logic [12:0] dropMs_reg;
  logic commSet;

  assign msTick = prescale_reg == PW'(TICK_CYCLES - 1);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prescale_reg <= '0;
    end else begin
      prescale_reg <= msTick ? '0 : PW'(prescale_reg + 1'b1);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      modeMs_reg <= '0;
      reqMs_reg <= '0;
      lowMs_reg <= '0;
      dropMs_reg <= '0;
    end else begin
      if (!transferMode) begin
        modeMs_reg <= '0;
      end else if (msTick) begin
        modeMs_reg <= bump(modeMs_reg);
      end
      if (!requestOut) begin
        reqMs_reg <= '0;
      end else if (msTick) begin
        reqMs_reg <= bump(reqMs_reg);
      end
      if (!transferMode || readyS) begin
        lowMs_reg <= '0;
      end else if (msTick) begin
        lowMs_reg <= bump(lowMs_reg);
      end
      if (!requestOut || !readyS) begin
        dropMs_reg <= '0;
      end else if (msTick) begin
        dropMs_reg <= bump(dropMs_reg);
      end
    end
  end

  assign commSet = modeMs_reg > `APTS_MODE_LIMIT_MS
                || reqMs_reg > `APTS_REQ_LIMIT_MS
                || lowMs_reg >= `APTS_READY_LIMIT_MS
                || dropMs_reg >= `APTS_REQ_LIMIT_MS;

  // ------------------------------------------------------------
  // Transfer sequencer
  // ------------------------------------------------------------
  apts_pkg::apts_state_type state_reg;
  logic [4:0] pairs_reg;
  logic [37:0] shift_reg;
  logic [2:0] misses_reg;
  logic sumMatch;
  logic fifoInReady;
  logic checkDone;
  logic sumSet;

  assign sumMatch = pairSum(shift_reg[31:0]) == shift_reg[37:`APTS_SUM_LSB];
  assign checkDone = state_reg == apts_pkg::CHECK;
  assign sumSet = checkDone && !sumMatch
               && misses_reg == 3'(`APTS_SUM_TRIES - 3'h1);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= apts_pkg::IDLE;
      pairs_reg <= '0;
      shift_reg <= '0;
      misses_reg <= '0;
    end else if (!sonS) begin
      state_reg <= apts_pkg::IDLE;
    end else if (servoAlarm || commSet) begin
      state_reg <= apts_pkg::HALT;
    end else begin
      case (state_reg)
        apts_pkg::IDLE: begin
          if (sonRise) begin
            misses_reg <= '0;
            state_reg <= apts_pkg::START;
          end
        end
        apts_pkg::START: begin
          pairs_reg <= '0;
          // The shared pin may still show torque status through the synchroniser,
          // so a stale high must drain before the first handshake counts.
          if (!readyS) begin
            state_reg <= apts_pkg::ACK;
          end
        end
        apts_pkg::ACK: begin
          if (readyS) begin
            state_reg <= (pairs_reg == `APTS_TOTAL_PAIRS) ? apts_pkg::CHECK : apts_pkg::REQ;
          end
        end
        apts_pkg::REQ: begin
          if (!readyS) begin
            // Low pair arrives first, checksum pairs after the data.
            shift_reg <= {bit1S, bit0S, shift_reg[37:2]};
            pairs_reg <= 5'(pairs_reg + 5'h1);
            state_reg <= apts_pkg::ACK;
          end
        end
        apts_pkg::CHECK: begin
          if (sumMatch) begin
            if (fifoInReady) begin
              misses_reg <= '0;
              state_reg <= apts_pkg::DONE;
            end
          end else if (sumSet) begin
            state_reg <= apts_pkg::HALT;
          end else begin
            misses_reg <= 3'(misses_reg + 3'h1);
            state_reg <= apts_pkg::GAP;
          end
        end
        apts_pkg::GAP: begin
          state_reg <= apts_pkg::START;
        end
        apts_pkg::DONE, apts_pkg::HALT: begin
          state_reg <= state_reg;
        end
        default: begin
          state_reg <= apts_pkg::IDLE;
        end
      endcase
    end
  end

  // The amplifier's own timeout warnings surface here as a stalled handshake.
  assign transferMode = state_reg == apts_pkg::START || state_reg == apts_pkg::ACK
                     || state_reg == apts_pkg::REQ || checkDone;
  assign requestOut = state_reg == apts_pkg::REQ;
  // Shared pin means transfer-ready only reports torque limiting outside transfer.
  assign torqueLimiting = readyS && !transferMode;

  // A stalled reader holds CHECK; the mode timer then flags the stall.
  apts_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .inValid(checkDone && sumMatch),
    .inReady(fifoInReady),
    .inData(shift_reg[31:0]),
    .outValid(posValid),
    .outReady(posReady),
    .outData(posData)
  );

  // ------------------------------------------------------------
  // Error and alarm flags
  // ------------------------------------------------------------
  logic commErr_reg;
  logic sumErr_reg;
  logic alarm_reg;
  logic sonOut_reg;
  logic alarmSet;
  logic sumClr;

  assign alarmSet = faultS || emgS;
  assign sumClr = MULTI_AXIS ? sonRise : !sonS;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      commErr_reg <= 1'b0;
    end else if (commSet) begin
      commErr_reg <= 1'b1;
    end else if (!sonS) begin
      commErr_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sumErr_reg <= 1'b0;
    end else if (sumSet) begin
      sumErr_reg <= 1'b1;
    end else if (sumClr) begin
      sumErr_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_reg <= 1'b0;
    end else if (alarmSet) begin
      alarm_reg <= 1'b1;
    end else if (arsRise) begin
      alarm_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sonOut_reg <= 1'b0;
    end else begin
      sonOut_reg <= sonS && !alarm_reg;
    end
  end

  assign commError = commErr_reg;
  assign sumError = sumErr_reg;
  assign servoAlarm = alarm_reg;
  assign servoOnCmd = sonOut_reg;

  // ------------------------------------------------------------
  // Serial position read command
  // ------------------------------------------------------------
  logic serValid_reg;
  logic [7:0] serStation_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      serValid_reg <= 1'b0;
      serStation_reg <= 8'h00;
    end else if (serialReq && !serValid_reg) begin
      serValid_reg <= 1'b1;
      serStation_reg <= stationNo;
    end else if (serialCmdReady) begin
      serValid_reg <= 1'b0;
    end
  end

  assign serialCmdValid = serValid_reg;
  assign serialStation = serStation_reg;
  assign serialCmdCode = `APTS_READ_CMD;
  assign serialDataNo = `APTS_READ_DATA_NO;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  mode_limit_a: assert property (modeMs_reg > `APTS_MODE_LIMIT_MS |=> commError)
    else $error("transfer mode overrun not flagged");
  ready_low_a: assert property (lowMs_reg >= `APTS_READY_LIMIT_MS |=> commError)
    else $error("ready low overrun not flagged");
  req_limit_a: assert property (reqMs_reg > `APTS_REQ_LIMIT_MS |=> commError)
    else $error("request overrun not flagged");
  drop_limit_a: assert property (dropMs_reg >= `APTS_REQ_LIMIT_MS |=> commError)
    else $error("ready drop overrun not flagged");
  sum_fourth_a: assert property (sumSet |=> sumError && state_reg == apts_pkg::HALT)
    else $error("fourth mismatch not flagged");
  alarm_set_a: assert property (alarmSet |=> servoAlarm)
    else $error("servo alarm not set");
  comm_clear_a: assert property (!sonS && !commSet |=> !commError)
    else $error("communication error not cleared");
  alarm_clear_a: assert property (arsRise && !alarmSet |=> !servoAlarm)
    else $error("servo alarm not cleared");
  torque_gate_a: assert property (transferMode |-> !torqueLimiting)
    else $error("torque limiting during transfer");
  start_edge_a: assert property ($rose(transferMode)
    |-> $past(sonRise) || $past(state_reg) == apts_pkg::GAP)
    else $error("transfer started without switch edge");
  miss_reset_a: assert property (checkDone && sumMatch && fifoInReady && sonS
    && !servoAlarm && !commSet |=> misses_reg == 3'h0 ##1 1'b1)
    else $error("mismatch count not cleared");
endmodule
`default_nettype wire

/* bench/apts_amp_model.sv */
// Amplifier side model: answers the two-bit position handshake of the supervisor.
`timescale 1ns/1ps
`default_nettype none

module apts_amp_model (
  input wire logic core_clk, // System clock.
  input wire logic transferMode, // Transfer mode from the supervisor.
  input wire logic requestOut, // Data request from the supervisor.
  input wire logic [31:0] position, // Position to report.
  input wire logic [1:0] fault, // 0 normal, 1 ready stuck high, 2 ready stuck low.
  input wire logic torqueIn, // Torque limit status shown outside transfers.
  output logic readyPin, // Transfer-ready pin.
  output logic bit0Pin, // Data bit 0 pin.
  output logic bit1Pin // Data bit 1 pin.
);
  int badLeft = 0;
  int idx = 0;
  int dly = 0;
  logic modeQ = 1'b0;
  logic bad = 1'b0;
  logic [5:0] sum;
  logic [37:0] frame;

  task automatic arm(input int n);
    badLeft = n;
  endtask

  always_comb begin
    sum = 6'h00;
    for (int i = 0; i < 16; i++) begin
      sum += {4'h0, position[2*i +: 2]};
    end
  end

  // Corrupted attempts flip the checksum low bit only, so the data pairs stay genuine.
  assign frame = {sum ^ {5'h00, bad}, position};

  initial begin
    readyPin = 1'b0;
    bit0Pin = 1'b0;
    bit1Pin = 1'b1;
  end

  always @(posedge core_clk) begin
    modeQ <= transferMode;
    if (!transferMode) begin
      idx <= 0;
      dly <= 0;
      // Ready stays low through a one-cycle retry gap so no false handshake is seen.
      readyPin <= modeQ ? 1'b0 : torqueIn;
      bit0Pin <= ~bit0Pin;
      bit1Pin <= ~bit1Pin;
    end else if (!modeQ) begin
      bad <= badLeft > 0;
      badLeft <= (badLeft > 0) ? badLeft - 1 : 0;
      readyPin <= 1'b0;
    end else if (fault != 2'h2 && readyPin == requestOut) begin
      dly <= dly + 1;
      if (dly == 3 && !(requestOut && fault == 2'h1)) begin
        dly <= 0;
        readyPin <= !requestOut;
        if (requestOut) begin
          {bit1Pin, bit0Pin} <= frame[2*idx +: 2];
          idx <= idx + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* bench/apts_supervisor_tb_top.sv */
// Self-checking bench for the transfer supervisor against the amplifier model.
`timescale 1ns/1ps
`default_nettype none
`include "apts_defs.svh"

module apts_supervisor_tb_top;
  localparam int TICK = 4;
  localparam int SEC = 1000 * TICK;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic servoOnSwitch, alarmResetSwitch, faultOutput, emergencyStopInput;
  logic readyPin, bit0Pin, bit1Pin, torqueIn, posReady, serialReq, serialCmdReady;
  logic [7:0] stationNo, serialStation, serialCmdCode, serialDataNo;
  logic servoOnCmd, transferMode, requestOut, torqueLimiting;
  logic commError, sumError, servoAlarm, posValid, serialCmdValid;
  logic [31:0] posData, position;
  logic [1:0] fault;
  logic sumErrorSingle;
  int fails = 0;
  int samplesChecked = 0;
  logic [31:0] expq[$];

  apts_supervisor #(.TICK_CYCLES(TICK), .MULTI_AXIS(1'b1), .FIFO_DEPTH(8)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .servoOnSwitch(servoOnSwitch),
    .alarmResetSwitch(alarmResetSwitch), .faultOutput(faultOutput),
    .emergencyStopInput(emergencyStopInput), .transferReadyOutput(readyPin),
    .positionBitZero(bit0Pin), .positionBitOne(bit1Pin), .servoOnCmd(servoOnCmd),
    .transferMode(transferMode), .requestOut(requestOut), .torqueLimiting(torqueLimiting),
    .commError(commError), .sumError(sumError), .servoAlarm(servoAlarm),
    .posValid(posValid), .posReady(posReady), .posData(posData), .serialReq(serialReq),
    .stationNo(stationNo), .serialCmdValid(serialCmdValid),
    .serialCmdReady(serialCmdReady), .serialStation(serialStation),
    .serialCmdCode(serialCmdCode), .serialDataNo(serialDataNo));

  // Single-axis variant on the same pins; only its checksum flag clear differs.
  apts_supervisor #(.TICK_CYCLES(TICK), .MULTI_AXIS(1'b0), .FIFO_DEPTH(8)) dutSingle (
    .core_clk(core_clk), .rst_n(rst_n), .servoOnSwitch(servoOnSwitch),
    .alarmResetSwitch(alarmResetSwitch), .faultOutput(faultOutput),
    .emergencyStopInput(emergencyStopInput), .transferReadyOutput(readyPin),
    .positionBitZero(bit0Pin), .positionBitOne(bit1Pin), .servoOnCmd(), .transferMode(),
    .requestOut(), .torqueLimiting(), .commError(), .sumError(sumErrorSingle),
    .servoAlarm(), .posValid(), .posReady(posReady), .posData(), .serialReq(serialReq),
    .stationNo(stationNo), .serialCmdValid(), .serialCmdReady(serialCmdReady),
    .serialStation(), .serialCmdCode(), .serialDataNo());

  apts_amp_model amp (
    .core_clk(core_clk), .transferMode(transferMode), .requestOut(requestOut),
    .position(position), .fault(fault), .torqueIn(torqueIn), .readyPin(readyPin),
    .bit0Pin(bit0Pin), .bit1Pin(bit1Pin));

  initial begin
    forever #4 core_clk = ~core_clk;
  end

  // ---------------------------------------------------------------
  // Shared helpers
  // ---------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    samplesChecked++;
    if (ok !== 1'b1) begin
      fails++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic waitFor(ref logic sig, input logic val, input int lim, output int n);
    n = 0;
    while (sig !== val && n < lim) begin
      @(negedge core_clk);
      n++;
    end
  endtask

  task automatic xfer(input logic [31:0] pos, input int bad);
    int n;
    position = pos;
    torqueIn = 1'b1;
    amp.arm(bad);
    servoOnSwitch = 1'b0;
    cyc(4);
    servoOnSwitch = 1'b1;
    waitFor(transferMode, 1'b1, 20, n);
    check(n < 20, "transfer not started on switch rise");
    check(torqueLimiting === 1'b0, "torque limiting during transfer");
    // A retry drops the mode for one cycle only, so keep waiting past each gap.
    repeat (5) begin
      waitFor(transferMode, 1'b0, 3000, n);
      cyc(5);
    end
    check(transferMode === 1'b0 && commError === 1'b0, "transfer did not finish");
    check(torqueLimiting === 1'b1, "torque status lost after transfer");
    if (bad < 4) begin
      expq.push_back(pos);
    end
  endtask

  task automatic drain();
    while (expq.size() > 0) begin
      cyc(2);
      check(posValid === 1'b1 && posData === expq.pop_front(), "position word");
      posReady = 1'b1;
      cyc(1);
      posReady = 1'b0;
    end
    cyc(2);
    check(posValid === 1'b0, "buffer not empty after drain");
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_serial();
    for (int s = 1; s < 64; s += 61) begin
      stationNo = 8'(s);
      serialReq = 1'b1;
      cyc(1);
      serialReq = 1'b0;
      stationNo = 8'hff;
      cyc(3);
      check(serialCmdValid === 1'b1 && serialStation === 8'(s), "station");
      check(serialCmdCode === `APTS_READ_CMD && serialDataNo === `APTS_READ_DATA_NO,
            "read command");
      cyc(3);
      check(serialCmdValid === 1'b1, "command dropped before accept");
      serialCmdReady = 1'b1;
      cyc(1);
      serialCmdReady = 1'b0;
      cyc(2);
      check(serialCmdValid === 1'b0, "command not retired");
    end
  endtask

  task automatic t_alarm();
    for (int s = 0; s < 2; s++) begin
      faultOutput = (s == 0);
      emergencyStopInput = (s == 1);
      cyc(6);
      servoOnSwitch = 1'b1;
      cyc(6);
      check(servoAlarm === 1'b1 && servoOnCmd === 1'b0, "alarm not raised");
      faultOutput = 1'b0;
      emergencyStopInput = 1'b0;
      cyc(6);
      check(servoAlarm === 1'b1, "alarm cleared without reset");
      alarmResetSwitch = 1'b1;
      cyc(6);
      check(servoAlarm === 1'b0 && servoOnCmd === 1'b1, "alarm not cleared");
      alarmResetSwitch = 1'b0;
      servoOnSwitch = 1'b0;
      cyc(6);
    end
  endtask

  task automatic t_stuck(input logic [1:0] f);
    int n;
    fault = f;
    torqueIn = 1'b0;
    servoOnSwitch = 1'b1;
    if (f == 2'h1) begin
      waitFor(requestOut, 1'b1, 200, n);
    end else begin
      waitFor(transferMode, 1'b1, 20, n);
    end
    waitFor(commError, 1'b1, SEC + 100, n);
    check(n > SEC - 3 * TICK && n < SEC + 4 * TICK, "timeout span");
    check(transferMode === 1'b0 && requestOut === 1'b0, "not halted on timeout");
    servoOnSwitch = 1'b0;
    cyc(5);
    check(commError === 1'b0, "error not cleared on switch low");
    fault = 2'h0;
  endtask

  task automatic t_sum();
    xfer(32'h0123_4567, 3);
    check(sumError === 1'b0, "three mismatches flagged");
    xfer(32'h89ab_cdef, 4);
    check(sumError === 1'b1 && sumErrorSingle === 1'b1, "four mismatches not flagged");
    servoOnSwitch = 1'b0;
    cyc(6);
    check(sumError === 1'b1, "checksum error cleared on switch low");
    check(sumErrorSingle === 1'b0, "single-axis checksum error kept on switch low");
    xfer(32'h7654_3210, 0);
    check(sumError === 1'b0, "checksum error kept on switch rise");
    drain();
  endtask

  task automatic t_fill();
    int n;
    for (int i = 0; i < 8; i++) begin
      xfer(32'hc3a5_0f00 ^ (i * 32'h1111_1111), 0);
    end
    servoOnSwitch = 1'b0;
    cyc(4);
    servoOnSwitch = 1'b1;
    waitFor(commError, 1'b1, 5 * SEC + 400, n);
    check(n > 5 * SEC - 3 * TICK && n < 5 * SEC + 40, "mode limit span");
    servoOnSwitch = 1'b0;
    cyc(5);
    check(commError === 1'b0, "error not cleared on switch low");
    drain();
  endtask

  initial begin
    servoOnSwitch = 1'b0;
    alarmResetSwitch = 1'b0;
    faultOutput = 1'b0;
    emergencyStopInput = 1'b0;
    posReady = 1'b0;
    serialReq = 1'b0;
    serialCmdReady = 1'b0;
    stationNo = 8'h00;
    position = 32'h0000_0000;
    fault = 2'h0;
    torqueIn = 1'b0;
    cyc(20);
    check(servoAlarm === 1'b0 && commError === 1'b0 && sumError === 1'b0, "reset flags");
    check(transferMode === 1'b0 && posValid === 1'b0, "reset outputs");
    rst_n = 1'b1;
    cyc(4);
    t_serial();
    t_alarm();
    t_stuck(2'h1);
    t_stuck(2'h2);
    t_sum();
    t_fill();
    final_report();
  end

  initial begin
    #(90000 * 8);
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    final_report();
  end
endmodule
`default_nettype wire
